// file: shared/sysreg_pkg.sv
// Register selects, field positions and fixed values of the interface control registers
package sysreg_pkg;
    localparam int REG_SEL_W = 4;
    localparam logic [3:0] SEL_MONITOR_IRQ_CONTROL = 4'h0;
    localparam logic [3:0] SEL_MONITOR_SYSREG_IFACE_ENABLE = 4'h1;
    localparam logic [3:0] SEL_EL1_SYSREG_IFACE_ENABLE = 4'h2;
    localparam logic [3:0] SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP0 = 4'h3;
    localparam logic [3:0] SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP1 = 4'h4;
    localparam logic [3:0] SEL_VIRTUAL_BINARY_POINT_GROUP0 = 4'h5;
    localparam logic [3:0] SEL_VIRTUAL_BINARY_POINT_GROUP1 = 4'h6;
    localparam logic [3:0] SEL_VIRTUAL_IFACE_CONTROL = 4'h7;
    localparam int POS_EOI_MODE_MONITOR = 2;
    localparam int POS_COMMON_BPR_NONSECURE = 1;
    localparam int POS_COMMON_BPR_SECURE = 0;
    localparam int POS_LOWER_ACCESS_ENABLE = 3;
    localparam int POS_IRQ_BYPASS_DISABLE = 2;
    localparam int POS_FIQ_BYPASS_DISABLE = 1;
    localparam int POS_SYSREG_IFACE_ENABLE_BIT = 0;
    localparam int POS_AFFINITY3_VALID = 15;
    localparam int POS_LOCAL_SERROR_SUPPORT = 14;
    localparam int POS_INTID_WIDTH_LO = 11;
    localparam int POS_PRIORITY_WIDTH_LO = 8;
    localparam int POS_VIRT_EOI_MODE = 1;
    localparam int POS_VIRT_COMMON_BINARY_POINT = 0;
    localparam logic AFFINITY3_VALID_VAL = 1'h1;
    localparam logic LOCAL_SERROR_SUPPORT_VAL = 1'h0;
    localparam logic [2:0] INTID_WIDTH_CODE_VAL = 3'h0;
    localparam logic [2:0] PRIORITY_WIDTH_CODE_VAL = 3'h4;
    localparam logic [2:0] BPR0_MIN = 3'h2;
    localparam logic [2:0] BPR1_MIN_SECURE = 3'h2;
    localparam logic [2:0] BPR1_MIN_NONSECURE = 3'h3;
    localparam logic [2:0] BPR_MAX = 3'h7;
    localparam logic [31:0] ACTIVE_PRIO_RESET = 32'h00000000;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [1:0] BYPASS_RESET = 2'h0;
    localparam logic [1:0] VCTRL_RESET = 2'h0;

    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] sel;
        logic [31:0] wdata;
    } sysreg_req_type;

    typedef struct packed {
        logic done;
        logic denied;
        logic [31:0] rdata;
    } sysreg_rsp_type;

    typedef enum logic [1:0] {
        EOI_OP_NONE = 2'b00,
        EOI_OP_DROP = 2'b01,
        EOI_OP_DROP_DEACT = 2'b10,
        EOI_OP_DEACT = 2'b11
    } eoi_op_type;
endpackage : sysreg_pkg

// file: hw/bpr_clamp.sv
// Binary point write clamp to an implemented minimum
`timescale 1ns/1ps
module bpr_clamp
    import sysreg_pkg::*;
(
    // Value and floor
    input wire logic [2:0] i_value,
    input wire logic [2:0] i_min,
    // Clamped result
    output logic [2:0] o_value
);
    assign o_value = (i_value < i_min) ? i_min : i_value;
endmodule : bpr_clamp

// file: hw/irq_cpu_if_sysreg_ctrl.sv
// Interrupt CPU interface control, enable and virtual interface system registers
// Overview of operation
// - Monitor EOI mode bit at position 2
// - Non-secure common binary point select, bit 1
// - Secure common binary point select, bit 0
// - Monitor control register accessible only when secure
// - Lower-level access enable bit 3 reads one
// - IRQ bypass disable bit 2
// - FIQ bypass disable bit 1
// - Sysreg interface enable bit 0 reads one
// - EL1 IRQ bypass disable aliases monitor bit
// - Active priority bit n means priority n*8
// - Active priority registers reset to zero
// - Group 0 binary point, minimum two
// - Group 1 minimum: secure two, nonsecure three
// - Affinity-3 valid reads one
// - Local system error support reads zero
// - Identifier width code reads zero
// - Priority width code reads four
// - Mode 0: EOI drops and deactivates
// - Mode 1: EOI drops; deactivate separately
// - Common point off: separate group points
// - Common point on: group1 reads group0+1 saturated
// - Common point on: group1 writes discarded
`timescale 1ns/1ps
module irq_cpu_if_sysreg_ctrl
    import sysreg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // System register access
    input wire sysreg_req_type i_req,
    input wire logic i_secure,
    input wire logic i_bpr1_nonsecure,
    output sysreg_rsp_type o_rsp,
    // Virtual end-of-interrupt and deactivate requests
    input wire logic i_veoi_g0,
    input wire logic i_veoi_g1,
    input wire logic i_vdeact,
    output eoi_op_type o_veoi_op,
    output logic o_vdeact_unpredictable,
    // Controls seen by the rest of the interface
    output logic o_eoi_mode_monitor,
    output logic o_common_bpr_nonsecure,
    output logic o_common_bpr_secure,
    output logic o_irq_bypass_disable,
    output logic o_fiq_bypass_disable,
    output logic [2:0] o_vbpr_group0,
    output logic [2:0] o_vbpr_group1,
    output logic [31:0] o_vap_group0,
    output logic [31:0] o_vap_group1
);
    logic [2:0] mon_ctrl_r;
    logic [1:0] bypass_r;
    logic [31:0] vap0_r;
    logic [31:0] vap1_r;
    logic [2:0] vbpr0_r;
    logic [2:0] vbpr1_r;
    logic [1:0] vctrl_r;
    logic [2:0] vbpr1_min;
    logic [2:0] vbpr0_wr;
    logic [2:0] vbpr1_wr;
    logic [2:0] vbpr1_view;
    logic wr;
    logic denied;
    logic [31:0] rdata_nxt;
    logic [31:0] sre_view;
    logic [31:0] vctrl_view;

    assign wr = i_req.valid && i_req.write && !denied;
    // Monitor control is refused outside the secure state
    assign denied = i_req.valid && !i_secure && (i_req.sel == SEL_MONITOR_IRQ_CONTROL);
    assign vbpr1_min = i_bpr1_nonsecure ? BPR1_MIN_NONSECURE : BPR1_MIN_SECURE;

    bpr_clamp u_clamp0 (
        .i_value(i_req.wdata[2:0]),
        .i_min(BPR0_MIN),
        .o_value(vbpr0_wr)
    );

    bpr_clamp u_clamp1 (
        .i_value(i_req.wdata[2:0]),
        .i_min(vbpr1_min),
        .o_value(vbpr1_wr)
    );

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mon_ctrl_r <= CONTROL_RESET;
        end else if (wr && i_req.sel == SEL_MONITOR_IRQ_CONTROL) begin
            mon_ctrl_r <= i_req.wdata[2:0];
        end
    end

    // One storage for both bypass views, so either write shows in both
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bypass_r <= BYPASS_RESET;
        end else if (wr && (i_req.sel == SEL_MONITOR_SYSREG_IFACE_ENABLE ||
                            i_req.sel == SEL_EL1_SYSREG_IFACE_ENABLE)) begin
            bypass_r <= i_req.wdata[POS_IRQ_BYPASS_DISABLE:POS_FIQ_BYPASS_DISABLE];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            vap0_r <= ACTIVE_PRIO_RESET;
            vap1_r <= ACTIVE_PRIO_RESET;
        end else begin
            if (wr && i_req.sel == SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP0) begin
                vap0_r <= i_req.wdata;
            end
            if (wr && i_req.sel == SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP1) begin
                vap1_r <= i_req.wdata;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            vbpr0_r <= BPR0_MIN;
        end else if (wr && i_req.sel == SEL_VIRTUAL_BINARY_POINT_GROUP0) begin
            vbpr0_r <= vbpr0_wr;
        end
    end

    // Reset value is the secure floor; a nonsecure read lifts it through the view
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            vbpr1_r <= BPR1_MIN_SECURE;
        end else if (wr && i_req.sel == SEL_VIRTUAL_BINARY_POINT_GROUP1 &&
                     !vctrl_r[POS_VIRT_COMMON_BINARY_POINT]) begin
            vbpr1_r <= vbpr1_wr;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            vctrl_r <= VCTRL_RESET;
        end else if (wr && i_req.sel == SEL_VIRTUAL_IFACE_CONTROL) begin
            vctrl_r <= i_req.wdata[1:0];
        end
    end

    always_comb begin
        if (vctrl_r[POS_VIRT_COMMON_BINARY_POINT]) begin
            vbpr1_view = (vbpr0_r == BPR_MAX) ? BPR_MAX : vbpr0_r + 3'h1;
        end else if (vbpr1_r < vbpr1_min) begin
            vbpr1_view = vbpr1_min;
        end else begin
            vbpr1_view = vbpr1_r;
        end
    end

    always_comb begin
        sre_view = 32'h00000000;
        sre_view[POS_IRQ_BYPASS_DISABLE] = bypass_r[1];
        sre_view[POS_FIQ_BYPASS_DISABLE] = bypass_r[0];
        sre_view[POS_SYSREG_IFACE_ENABLE_BIT] = 1'b1;
        vctrl_view = 32'h00000000;
        vctrl_view[POS_AFFINITY3_VALID] = AFFINITY3_VALID_VAL;
        vctrl_view[POS_LOCAL_SERROR_SUPPORT] = LOCAL_SERROR_SUPPORT_VAL;
        vctrl_view[POS_INTID_WIDTH_LO +: 3] = INTID_WIDTH_CODE_VAL;
        vctrl_view[POS_PRIORITY_WIDTH_LO +: 3] = PRIORITY_WIDTH_CODE_VAL;
        vctrl_view[1:0] = vctrl_r;
    end

    always_comb begin
        rdata_nxt = 32'h00000000;
        case (i_req.sel)
            SEL_MONITOR_IRQ_CONTROL: begin
                rdata_nxt[2:0] = mon_ctrl_r;
            end
            SEL_MONITOR_SYSREG_IFACE_ENABLE: begin
                rdata_nxt = sre_view;
                rdata_nxt[POS_LOWER_ACCESS_ENABLE] = 1'b1;
            end
            SEL_EL1_SYSREG_IFACE_ENABLE: begin
                rdata_nxt = sre_view;
            end
            SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP0: begin
                rdata_nxt = vap0_r;
            end
            SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP1: begin
                rdata_nxt = vap1_r;
            end
            SEL_VIRTUAL_BINARY_POINT_GROUP0: begin
                rdata_nxt[2:0] = vbpr0_r;
            end
            SEL_VIRTUAL_BINARY_POINT_GROUP1: begin
                rdata_nxt[2:0] = vbpr1_view;
            end
            SEL_VIRTUAL_IFACE_CONTROL: begin
                rdata_nxt = vctrl_view;
            end
            default: begin
                rdata_nxt = 32'h00000000;
            end
        endcase
    end

    // Answer one cycle after the request; denied reads return zero
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rsp <= '0;
        end else begin
            o_rsp.done <= i_req.valid;
            o_rsp.denied <= denied;
            o_rsp.rdata <= (i_req.valid && !i_req.write && !denied) ? rdata_nxt : 32'h00000000;
        end
    end

    // End-of-interrupt decode; data output registered
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_veoi_op <= EOI_OP_NONE;
            o_vdeact_unpredictable <= 1'b0;
        end else begin
            o_vdeact_unpredictable <= i_vdeact && !vctrl_r[POS_VIRT_EOI_MODE];
            if (i_veoi_g0 || i_veoi_g1) begin
                o_veoi_op <= vctrl_r[POS_VIRT_EOI_MODE] ? EOI_OP_DROP
                                                        : EOI_OP_DROP_DEACT;
            end else if (i_vdeact && vctrl_r[POS_VIRT_EOI_MODE]) begin
                o_veoi_op <= EOI_OP_DEACT;
            end else begin
                o_veoi_op <= EOI_OP_NONE;
            end
        end
    end

    assign o_eoi_mode_monitor = mon_ctrl_r[POS_EOI_MODE_MONITOR];
    assign o_common_bpr_nonsecure = mon_ctrl_r[POS_COMMON_BPR_NONSECURE];
    assign o_common_bpr_secure = mon_ctrl_r[POS_COMMON_BPR_SECURE];
    assign o_irq_bypass_disable = bypass_r[1];
    assign o_fiq_bypass_disable = bypass_r[0];
    assign o_vbpr_group0 = vbpr0_r;
    assign o_vbpr_group1 = vbpr1_view;
    assign o_vap_group0 = vap0_r;
    assign o_vap_group1 = vap1_r;

    a_mon_denied: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_req.valid && i_req.write && !i_secure && i_req.sel == SEL_MONITOR_IRQ_CONTROL)
        |=> $stable(mon_ctrl_r))
        else $error("monitor control changed by nonsecure write");
    a_mon_answer: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_req.valid && !i_secure && i_req.sel == SEL_MONITOR_IRQ_CONTROL)
        |=> o_rsp.done && o_rsp.denied && o_rsp.rdata == 32'h00000000)
        else $error("nonsecure monitor access not refused");
    a_sre_reads_one: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_req.valid && !i_req.write && i_req.sel == SEL_EL1_SYSREG_IFACE_ENABLE)
        |=> o_rsp.rdata[0] && !o_rsp.rdata[3])
        else $error("enable register read wrong fixed bits");
    a_bypass_alias: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_req.valid && i_req.write && i_req.sel == SEL_EL1_SYSREG_IFACE_ENABLE)
        |=> o_irq_bypass_disable == $past(i_req.wdata[2]))
        else $error("bypass alias not updated");
    a_vctrl_fixed: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_req.valid && !i_req.write && i_req.sel == SEL_VIRTUAL_IFACE_CONTROL)
        |=> o_rsp.rdata[15:8] == 8'h84)
        else $error("virtual control feature fields wrong");
    a_bpr1_common: assert property (@(posedge i_clk) disable iff (i_srst)
        vctrl_r[0] |-> o_vbpr_group1 == ((vbpr0_r == 3'h7) ? 3'h7 : vbpr0_r + 3'h1))
        else $error("common group1 view wrong");
    a_bpr1_discard: assert property (@(posedge i_clk) disable iff (i_srst)
        (vctrl_r[0] && i_req.valid && i_req.write) |=> $stable(vbpr1_r))
        else $error("group1 point written while common");
    a_bpr0_floor: assert property (@(posedge i_clk) disable iff (i_srst)
        o_vbpr_group0 >= 3'h2)
        else $error("group0 point below floor");
    a_eoi_mode: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_veoi_g0 && !vctrl_r[1]) |=> o_veoi_op == EOI_OP_DROP_DEACT)
        else $error("eoi mode 0 did not deactivate");
    a_eoi_drop: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_veoi_g1 && vctrl_r[1]) |=> o_veoi_op == EOI_OP_DROP)
        else $error("eoi mode 1 deactivated");
    c_common_on: cover property (@(posedge i_clk) vctrl_r[0] && vbpr0_r == 3'h7);
    c_denied: cover property (@(posedge i_clk) o_rsp.denied);
    c_deact: cover property (@(posedge i_clk) o_veoi_op == EOI_OP_DEACT);
endmodule : irq_cpu_if_sysreg_ctrl

// file: dv/irq_cpu_if_sysreg_ctrl_test.sv
// Self-checking testbench for the interrupt CPU interface system registers
`timescale 1ns/1ps
module irq_cpu_if_sysreg_ctrl_test
    import sysreg_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    sysreg_req_type req = '0;
    logic sec = 1'b1;
    logic bnn = 1'b0;
    logic veoi_g0 = 1'b0;
    logic veoi_g1 = 1'b0;
    logic vdeact = 1'b0;
    sysreg_rsp_type rsp;
    eoi_op_type op;
    logic unp, eoi_m, cbns, cbs, irqd, fiqd;
    logic [2:0] bp0, bp1;
    logic [31:0] vap0, vap1;
    int bad_count = 0;
    int n_compared = 0;

    irq_cpu_if_sysreg_ctrl i_irq_cpu_if_sysreg_ctrl (
        .i_clk(i_clk), .i_srst(i_srst), .i_req(req), .i_secure(sec),
        .i_bpr1_nonsecure(bnn), .o_rsp(rsp), .i_veoi_g0(veoi_g0), .i_veoi_g1(veoi_g1),
        .i_vdeact(vdeact), .o_veoi_op(op), .o_vdeact_unpredictable(unp),
        .o_eoi_mode_monitor(eoi_m), .o_common_bpr_nonsecure(cbns),
        .o_common_bpr_secure(cbs), .o_irq_bypass_disable(irqd),
        .o_fiq_bypass_disable(fiqd), .o_vbpr_group0(bp0), .o_vbpr_group1(bp1),
        .o_vap_group0(vap0), .o_vap_group1(vap1)
    );

    always #12.5 i_clk = ~i_clk;

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Request is held through the taking edge, answer waited for under a bound
    task automatic acc(input logic w, input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] rd, output logic den);
        int k;
        req = {1'b1, w, s, d};
        @(posedge i_clk);
        #1;
        req.valid = 1'b0;
        for (k = 0; k < 4 && rsp.done !== 1'b1; k++) begin
            @(posedge i_clk);
            #1;
        end
        if (rsp.done !== 1'b1) begin
            bad_count++;
            conclude();
        end else begin
            rd = rsp.rdata;
            den = rsp.denied;
            // One idle edge, so the next call never re-raises valid in this time step
            @(posedge i_clk);
            #1;
        end
    endtask : acc

    task automatic wr(input logic [3:0] s, input logic [31:0] d);
        logic [31:0] r;
        logic dn;
        acc(1'b1, s, d, r, dn);
    endtask : wr

    task automatic rc(input logic [3:0] s, input logic [31:0] e, input string n);
        logic [31:0] r;
        logic dn;
        acc(1'b0, s, 32'h0, r, dn);
        chk(n, r, e);
    endtask : rc

    task automatic pulse(input int w, input logic [1:0] e_op, input logic e_unp);
        veoi_g0 = (w == 0);
        veoi_g1 = (w == 1);
        vdeact = (w == 2);
        @(posedge i_clk);
        #1;
        veoi_g0 = 1'b0;
        veoi_g1 = 1'b0;
        vdeact = 1'b0;
        chk("veoi_op", {30'h0, op}, {30'h0, e_op});
        chk("vdeact_unpredictable", {31'h0, unp}, {31'h0, e_unp});
        // Idle edge keeps back-to-back pulses apart
        @(posedge i_clk);
        #1;
    endtask : pulse

    task automatic t_reset();
        rc(SEL_MONITOR_IRQ_CONTROL, 32'h0, "mon_ctrl");
        rc(SEL_MONITOR_SYSREG_IFACE_ENABLE, 32'h9, "mon_enable");
        rc(SEL_EL1_SYSREG_IFACE_ENABLE, 32'h1, "el1_enable");
        rc(SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP0, 32'h0, "vap0");
        rc(SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP1, 32'h0, "vap1");
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP0, 32'h2, "vbpr0");
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h2, "vbpr1");
        rc(SEL_VIRTUAL_IFACE_CONTROL, 32'h8400, "vctrl");
        rc(4'h8, 32'h0, "unmapped");
    endtask : t_reset

    // Reset in mid-run must clear the priorities and virtual control and return the binary points to their floor of two after earlier scenarios wrote them
    task automatic t_reset_again();
        i_srst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        i_srst = 1'b0;
        chk("vap_after_reset", vap0 | vap1, 32'h0);
        chk("bpr_after_reset", {26'h0, bp0, bp1}, 32'h12);
        rc(SEL_VIRTUAL_IFACE_CONTROL, 32'h8400, "vctrl_after_reset");
    endtask : t_reset_again

    task automatic t_monitor();
        logic [31:0] r;
        logic dn;
        wr(SEL_MONITOR_IRQ_CONTROL, 32'h7);
        chk("ctrl_bits", {29'h0, eoi_m, cbns, cbs}, 32'h7);
        sec = 1'b0;
        acc(1'b1, SEL_MONITOR_IRQ_CONTROL, 32'h0, r, dn);
        chk("ns_write_denied", {31'h0, dn}, 32'h1);
        acc(1'b0, SEL_MONITOR_IRQ_CONTROL, 32'h0, r, dn);
        chk("ns_read_data", r, 32'h0);
        sec = 1'b1;
        rc(SEL_MONITOR_IRQ_CONTROL, 32'h7, "ctrl_kept");
        wr(SEL_MONITOR_IRQ_CONTROL, 32'h2);
        chk("ctrl_bits2", {29'h0, eoi_m, cbns, cbs}, 32'h2);
    endtask : t_monitor

    task automatic t_bypass();
        // Fixed-one bits written as zero must still read one
        wr(SEL_MONITOR_SYSREG_IFACE_ENABLE, 32'h4);
        chk("bypass_pins", {30'h0, irqd, fiqd}, 32'h2);
        rc(SEL_EL1_SYSREG_IFACE_ENABLE, 32'h5, "el1_alias");
        wr(SEL_EL1_SYSREG_IFACE_ENABLE, 32'h2);
        chk("bypass_pins2", {30'h0, irqd, fiqd}, 32'h1);
        rc(SEL_MONITOR_SYSREG_IFACE_ENABLE, 32'hB, "mon_alias");
    endtask : t_bypass

    task automatic t_vap();
        wr(SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP0, 32'h80000001);
        wr(SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP1, 32'h00000002);
        rc(SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP0, 32'h80000001, "vap0_rd");
        rc(SEL_VIRTUAL_ACTIVE_PRIORITIES_GROUP1, 32'h00000002, "vap1_rd");
        chk("vap_pins", vap0 ^ vap1, 32'h80000003);
    endtask : t_vap

    task automatic t_bpr();
        wr(SEL_VIRTUAL_BINARY_POINT_GROUP0, 32'h0);
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP0, 32'h2, "vbpr0_clamp");
        wr(SEL_VIRTUAL_BINARY_POINT_GROUP0, 32'h7);
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP0, 32'h7, "vbpr0_max");
        wr(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h1);
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h2, "vbpr1_s_min");
        bnn = 1'b1;
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h3, "vbpr1_ns_view");
        wr(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h1);
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h3, "vbpr1_ns_min");
        bnn = 1'b0;
        wr(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h4);
        chk("bpr_pins", {26'h0, bp0, bp1}, 32'h3C);
    endtask : t_bpr

    task automatic t_common();
        wr(SEL_VIRTUAL_IFACE_CONTROL, 32'h1);
        rc(SEL_VIRTUAL_IFACE_CONTROL, 32'h8401, "vctrl_cbp");
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h7, "vbpr1_sat");
        wr(SEL_VIRTUAL_BINARY_POINT_GROUP0, 32'h3);
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h4, "vbpr1_plus1");
        wr(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h6);
        wr(SEL_VIRTUAL_IFACE_CONTROL, 32'h0);
        rc(SEL_VIRTUAL_BINARY_POINT_GROUP1, 32'h4, "vbpr1_kept");
    endtask : t_common

    task automatic t_eoi();
        pulse(0, 2'h2, 1'b0);
        pulse(1, 2'h2, 1'b0);
        pulse(2, 2'h0, 1'b1);
        wr(SEL_VIRTUAL_IFACE_CONTROL, 32'h2);
        pulse(0, 2'h1, 1'b0);
        pulse(1, 2'h1, 1'b0);
        pulse(2, 2'h3, 1'b0);
    endtask : t_eoi

    initial begin
        repeat (16) @(posedge i_clk);
        #1;
        i_srst = 1'b0;
        t_reset();
        t_monitor();
        t_bypass();
        t_vap();
        t_bpr();
        t_common();
        t_eoi();
        t_reset_again();
        conclude();
    end
endmodule : irq_cpu_if_sysreg_ctrl_test
